// File: design/lpm_controller.sv
// lpm_controller: operating mode sequencer for a small microcontroller
// How it works
// - standby instruction in active enters standby
// - standby keeps oscillators, stops cpu clock
// - standby runs peripherals, halts comparator
// - standby ends on reset or interrupt
// - interrupt wake resumes next instruction, active
// - halt in active with timer bit zero enters stop
// - sub oscillator in stop follows halt select
// - stop exit restarts at address zero
// - ram valid flag records stop exit cause
// - reset always works, wake pin only stop
// - watch entered from active or subactive
// - watch runs sub oscillator and timer a
// - watch serial runs only on external clock, interrupt suppressed
// - active clocks everything from main oscillator
// - watch wake goes active or subactive
// - direct transition goes active after settling
// - pending unmasked request with global interrupts disabled makes halt a nop
`timescale 1ns/1ps
`default_nettype none
module lpm_controller #(
  parameter logic [19:0] SettleCycles = 20'(lpm_pkg::SettleCycles)
) (
  input wire logic clock, // 40 MHz clock
  input wire logic nrst, // reset pin, async, active low
  input wire logic haltInstr, // pulse: halt instruction executed
  input wire logic standbyInstr, // pulse: standby instruction executed
  input wire logic timerAModeBit3, // timer a mode bit 3
  input wire logic lowSpeedSelect, // low speed flag
  input wire logic directTransitionFlag, // direct transition flag
  input wire logic subOscHaltSel, // 1 halts sub osc in stop
  input wire logic irqGlobalEnable, // global interrupt enable
  input wire logic irqPending, // some unmasked request flag set
  input wire logic timerAIrq, // timer a interrupt request
  input wire logic extIrq0N, // external interrupt 0, active low
  input wire logic wakeFromHaltN, // stop clear input, active low
  input wire logic serialExtClock, // serial uses external clock
  output logic [2:0] mode, // current mode code
  output logic mainOscEn, // main oscillator enable
  output logic subOscEn, // sub oscillator enable
  output logic cpuClockEn, // cpu instruction clock enable
  output logic cpuUseSubClock, // cpu clocked from sub oscillator
  output logic periphEn, // timers c d and interrupts run
  output logic serialEn, // serial interface runs
  output logic serialIrqEn, // serial interrupt allowed
  output logic comparatorEn, // comparator runs
  output logic timerAEn, // timer a runs
  output logic ioHold, // output port pins held
  output logic ioHighZ, // port pins high impedance
  output logic cpuRestart, // pulse: restart at start address
  output logic [11:0] restartAddr, // restart address
  output logic nopInstr, // pulse: halt treated as nop
  output logic ramValidFlag // ram valid flag
);
  lpm_pkg::lpm_mode_t state; // encoded mode register
  lpm_pkg::lpm_mode_t next_state;
  logic settleStart; // pulse into the settle counter
  logic next_settleStart;
  logic settleDone; // settle counter expired
  logic settleToSub; // after settling go subactive
  logic next_settleToSub;
  logic next_cpuRestart;
  logic next_nopInstr;
  logic next_ramValidFlag;
  logic restartPending; // restart once settling finishes
  logic next_restartPending;
  logic next_mainOscEn, next_subOscEn, next_cpuClockEn;
  logic next_cpuUseSubClock, next_periphEn, next_serialEn;
  logic next_serialIrqEn, next_comparatorEn, next_timerAEn;
  logic next_ioHold, next_ioHighZ;
  logic instr; // either low power instruction
  logic cancel; // instruction cancelled as nop
  logic watchWake; // timer a or ext irq 0 wake

  assign instr = haltInstr | standbyInstr;
  assign cancel = instr & ~irqGlobalEnable & irqPending;
  assign watchWake = timerAIrq | ~extIrq0N;

  // oscillator settling wait
  lpm_settle_counter #(
    .Cycles(SettleCycles)
  ) uSettle (
    .clock(clock),
    .nrst(nrst),
    .start(settleStart),
    .done(settleDone)
  );

  // next mode, settle requests and flags
  always_comb begin
    next_state = state;
    next_settleStart = 1'h0;
    next_settleToSub = settleToSub;
    next_cpuRestart = 1'h0;
    next_nopInstr = 1'h0;
    next_ramValidFlag = ramValidFlag;
    next_restartPending = restartPending;
    case (state)
      lpm_pkg::LPM_ACTIVE: begin
        if (cancel) begin
          next_nopInstr = 1'h1;
        end else if (standbyInstr) begin
          next_state = lpm_pkg::LPM_STANDBY;
        end else if (haltInstr) begin
          if (timerAModeBit3 == lpm_pkg::TimerAWatch) begin
            next_state = lpm_pkg::LPM_WATCH;
          end else begin
            next_state = lpm_pkg::LPM_STOP;
          end
        end
      end
      lpm_pkg::LPM_STANDBY: begin
        if (irqPending | timerAIrq) begin
          next_state = lpm_pkg::LPM_ACTIVE;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (!wakeFromHaltN) begin
          next_ramValidFlag = lpm_pkg::RamValidStopClr;
          next_restartPending = 1'h1;
          next_settleToSub = 1'h0;
          next_settleStart = 1'h1;
          next_state = lpm_pkg::LPM_SETTLE;
        end
      end
      lpm_pkg::LPM_WATCH: begin
        // wake target from low speed flag
        if (watchWake) begin
          if (lowSpeedSelect) begin
            next_state = lpm_pkg::LPM_SUBACT;
          end else begin
            next_settleToSub = 1'h0;
            next_settleStart = 1'h1;
            next_state = lpm_pkg::LPM_SETTLE;
          end
        end
      end
      lpm_pkg::LPM_SUBACT: begin
        if (cancel) begin
          next_nopInstr = 1'h1;
        end else if (instr) begin
          if (!lowSpeedSelect && directTransitionFlag) begin
            next_settleToSub = 1'h0;
            next_settleStart = 1'h1;
            next_state = lpm_pkg::LPM_SETTLE;
          end else begin
            next_state = lpm_pkg::LPM_WATCH;
          end
        end
      end
      lpm_pkg::LPM_SETTLE: begin
        if (settleDone) begin
          next_state = settleToSub ? lpm_pkg::LPM_SUBACT :
                       lpm_pkg::LPM_ACTIVE;
          next_cpuRestart = restartPending;
          next_restartPending = 1'h0;
        end
      end
      default: begin
        next_state = lpm_pkg::LPM_ACTIVE;
      end
    endcase
  end

  // per mode clock and function gating
  always_comb begin
    next_mainOscEn = 1'h1;
    next_subOscEn = 1'h1;
    next_cpuClockEn = 1'h0;
    next_cpuUseSubClock = 1'h0;
    next_periphEn = 1'h0;
    next_serialEn = 1'h0;
    next_serialIrqEn = 1'h0;
    next_comparatorEn = 1'h0;
    next_timerAEn = 1'h0;
    next_ioHold = 1'h0;
    next_ioHighZ = 1'h0;
    case (next_state)
      lpm_pkg::LPM_ACTIVE: begin
        next_cpuClockEn = 1'h1;
        next_periphEn = 1'h1;
        next_serialEn = 1'h1;
        next_serialIrqEn = 1'h1;
        next_comparatorEn = 1'h1;
        next_timerAEn = 1'h1;
      end
      lpm_pkg::LPM_STANDBY: begin
        next_periphEn = 1'h1;
        next_serialEn = 1'h1;
        next_serialIrqEn = 1'h1;
        next_timerAEn = 1'h1;
        next_ioHold = 1'h1;
      end
      lpm_pkg::LPM_STOP: begin
        // main osc off, sub osc by select
        next_mainOscEn = 1'h0;
        next_subOscEn = (subOscHaltSel != lpm_pkg::SubOscHaltStop);
        next_ioHighZ = 1'h1;
      end
      lpm_pkg::LPM_WATCH: begin
        // only timer a, serial on ext clock w/o irq
        next_mainOscEn = 1'h0;
        next_timerAEn = 1'h1;
        next_serialEn = serialExtClock;
        next_ioHold = 1'h1;
      end
      lpm_pkg::LPM_SUBACT: begin
        next_mainOscEn = 1'h0;
        next_cpuClockEn = 1'h1;
        next_cpuUseSubClock = 1'h1;
        next_periphEn = 1'h1;
        next_serialEn = 1'h1;
        next_serialIrqEn = 1'h1;
        next_comparatorEn = 1'h1;
        next_timerAEn = 1'h1;
      end
      default: begin
        // settling: main osc up, cpu clock held off
        next_ioHold = 1'h1;
      end
    endcase
  end

  // register state and outputs; reset pin is the reset exit
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= lpm_pkg::LPM_ACTIVE;
      settleStart <= 1'h0;
      settleToSub <= 1'h0;
      cpuRestart <= 1'h0;
      nopInstr <= 1'h0;
      ramValidFlag <= lpm_pkg::RamValidReset;
      restartPending <= 1'h0;
      mode <= 3'h0;
      mainOscEn <= 1'h1;
      subOscEn <= 1'h1;
      cpuClockEn <= 1'h0;
      cpuUseSubClock <= 1'h0;
      periphEn <= 1'h0;
      serialEn <= 1'h0;
      serialIrqEn <= 1'h0;
      comparatorEn <= 1'h0;
      timerAEn <= 1'h0;
      ioHold <= 1'h0;
      ioHighZ <= 1'h0;
      restartAddr <= lpm_pkg::StartAddr;
    end else begin
      state <= next_state;
      settleStart <= next_settleStart;
      settleToSub <= next_settleToSub;
      cpuRestart <= next_cpuRestart;
      nopInstr <= next_nopInstr;
      ramValidFlag <= next_ramValidFlag;
      restartPending <= next_restartPending;
      mode <= next_state;
      mainOscEn <= next_mainOscEn;
      subOscEn <= next_subOscEn;
      cpuClockEn <= next_cpuClockEn;
      cpuUseSubClock <= next_cpuUseSubClock;
      periphEn <= next_periphEn;
      serialEn <= next_serialEn;
      serialIrqEn <= next_serialIrqEn;
      comparatorEn <= next_comparatorEn;
      timerAEn <= next_timerAEn;
      ioHold <= next_ioHold;
      ioHighZ <= next_ioHighZ;
      restartAddr <= lpm_pkg::StartAddr;
    end
  end

  a_standby_entry: assert property (@(posedge clock) disable iff (!nrst)
    (state == lpm_pkg::LPM_ACTIVE && standbyInstr && !cancel)
    |=> state == lpm_pkg::LPM_STANDBY) else $error("no standby");
  a_standby_cpu: assert property (@(posedge clock) disable iff (!nrst)
    mode == lpm_pkg::LPM_STANDBY |-> !cpuClockEn && mainOscEn && subOscEn
    && !comparatorEn && periphEn) else $error("standby gating");
  a_stop_osc: assert property (@(posedge clock) disable iff (!nrst)
    mode == lpm_pkg::LPM_STOP |-> !mainOscEn && !cpuClockEn)
    else $error("stop osc");
  a_stop_sub: assert property (@(posedge clock) disable iff (!nrst)
    (next_state == lpm_pkg::LPM_STOP && state == lpm_pkg::LPM_STOP)
    |=> subOscEn == !$past(subOscHaltSel)) else $error("sub osc");
  a_ram_valid: assert property (@(posedge clock) disable iff (!nrst)
    (state == lpm_pkg::LPM_STOP && !wakeFromHaltN)
    |=> ramValidFlag) else $error("ram valid");
  a_wake_from_halt_n_ignore: assert property (@(posedge clock) disable iff (!nrst)
    (state == lpm_pkg::LPM_ACTIVE && !wakeFromHaltN && !instr)
    |=> state == lpm_pkg::LPM_ACTIVE) else $error("wake_from_halt_n used");
  a_nop_cancel: assert property (@(posedge clock) disable iff (!nrst)
    (state == lpm_pkg::LPM_ACTIVE && cancel)
    |=> nopInstr && state == lpm_pkg::LPM_ACTIVE) else $error("nop");
  a_watch_wake: assert property (@(posedge clock) disable iff (!nrst)
    (state == lpm_pkg::LPM_WATCH && watchWake && lowSpeedSelect)
    |=> state == lpm_pkg::LPM_SUBACT) else $error("watch wake");
  a_settle_cpu: assert property (@(posedge clock) disable iff (!nrst)
    state == lpm_pkg::LPM_SETTLE |-> !cpuClockEn)
    else $error("cpu clock early");
endmodule
`default_nettype wire

// File: include/lpm_pkg.sv
// lpm_pkg: constants and types for the low power mode controller
package lpm_pkg;
  // clock rate of the controller clock
  localparam int ClockHz = 40000000;
  // oscillator settle time in microseconds, default figure
  localparam int SettleTimeUs = 7813;
  // settle count in clock cycles, 40 per microsecond
  localparam int SettleCycles = (SettleTimeUs * 40 + 0);
  localparam int CntW = 20;
  // reset value of ram valid flag
  localparam logic RamValidReset = 1'h0;
  localparam logic RamValidStopClr = 1'h1;
  // program start address after stop clear
  localparam logic [11:0] StartAddr = 12'h000;
  // timer a mode bit value selecting watch on halt
  localparam logic TimerAWatch = 1'h1;
  // sub osc halt select value that stops it in stop mode
  localparam logic SubOscHaltStop = 1'h1;

  typedef enum logic [2:0] {
    LPM_ACTIVE = 3'b000,
    LPM_STANDBY = 3'b001,
    LPM_STOP = 3'b010,
    LPM_WATCH = 3'b011,
    LPM_SUBACT = 3'b100,
    LPM_SETTLE = 3'b101
  } lpm_mode_t;
endpackage

// File: design/lpm_settle_counter.sv
// lpm_settle_counter: oscillator stabilisation wait counter
`timescale 1ns/1ps
`default_nettype none
module lpm_settle_counter #(
  parameter logic [19:0] Cycles = 20'(lpm_pkg::SettleCycles)
) (
  input wire logic clock, // main clock
  input wire logic nrst, // async reset, active low
  input wire logic start, // pulse: begin counting
  output logic done // pulse: count expired
);
  logic [19:0] count; // remaining cycles
  logic [19:0] next_count;
  logic running; // counting in progress
  logic next_running;
  logic next_done;

  // next value of the down counter
  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'h0;
    if (start) begin
      next_count = Cycles;
      next_running = 1'h1;
    end else if (running) begin
      if (count <= 20'h00001) begin
        next_running = 1'h0;
        next_done = 1'h1;
      end else begin
        next_count = count - 20'h00001;
      end
    end
  end

  // register the counter
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= 20'h00000;
      running <= 1'h0;
      done <= 1'h0;
    end else begin
      count <= next_count;
      running <= next_running;
      done <= next_done;
    end
  end
endmodule
`default_nettype wire

// File: testbench/lpm_cpu_model.sv
// lpm_cpu_model: cpu core and wake pins driving the controller
`timescale 1ns/1ps
`default_nettype none
module lpm_cpu_model (
  input wire logic clock, // controller clock
  output var logic haltInstr, // halt pulse
  output var logic standbyInstr, // standby pulse
  output var logic timerAModeBit3, // timer a mode bit 3
  output var logic lowSpeedSelect, // low speed flag
  output var logic directTransitionFlag, // direct transition flag
  output var logic subOscHaltSel, // sub osc stop select
  output var logic irqGlobalEnable, // global interrupt enable
  output var logic irqPending, // unmasked request set
  output var logic timerAIrq, // timer a request
  output var logic extIrq0N, // external interrupt 0, active low
  output var logic wakeFromHaltN, // stop clear pin, active low
  output var logic serialExtClock // serial external clock
);
  logic portCWakePinFunc; // software copy of the port c pin function
  // idle levels: no request, pins released high
  initial begin
    {haltInstr, standbyInstr, timerAModeBit3, lowSpeedSelect} = 4'h0;
    {directTransitionFlag, subOscHaltSel, irqPending, timerAIrq} = 4'h0;
    {irqGlobalEnable, extIrq0N, wakeFromHaltN} = 3'h7;
    serialExtClock = 1'h0;
    // pin set up for stop clear before any stop
    portCWakePinFunc = 1'h1;
  end
  // one cycle instruction pulse; standby_instr picks standby over halt
  task automatic instr(input bit standby_instr);
    @(posedge clock);
    if (standby_instr) standbyInstr <= 1'h1;
    else haltInstr <= 1'h1;
    @(posedge clock);
    standbyInstr <= 1'h0;
    haltInstr <= 1'h0;
  endtask
endmodule
`default_nettype wire

// File: testbench/low_power_mode_controller_bench.sv
// low_power_mode_controller_bench: self-checking mode sequencer bench
`timescale 1ns/1ps
`default_nettype none
module low_power_mode_controller_bench;
  localparam int Settle = 16; // short settle count for simulation
  logic clock, nrst; // clock and reset pin
  int nErrors, samplesChecked, cyc, n, i; // counters
  logic [31:0] seed; // random seed
  logic sel; // sub osc select for stop
  wire logic hI, sI, tA3, lS, dT, sH, iE, iP, tI, e0N, wN, sX; // cpu side
  logic [2:0] mode; // mode code
  logic mO, sO, cC, cS, pE, sE, sIE, cE, tE, iH, iZ, cR, nop, rV; // outputs
  logic [11:0] rA; // restart address
  lpm_cpu_model cpu_u (.clock(clock), .haltInstr(hI), .standbyInstr(sI),
    .timerAModeBit3(tA3), .lowSpeedSelect(lS), .directTransitionFlag(dT),
    .subOscHaltSel(sH), .irqGlobalEnable(iE), .irqPending(iP),
    .timerAIrq(tI), .extIrq0N(e0N), .wakeFromHaltN(wN),
    .serialExtClock(sX));
  lpm_controller #(.SettleCycles(20'(Settle))) dut_u (.clock(clock),
    .nrst(nrst), .haltInstr(hI), .standbyInstr(sI), .timerAModeBit3(tA3),
    .lowSpeedSelect(lS), .directTransitionFlag(dT), .subOscHaltSel(sH),
    .irqGlobalEnable(iE), .irqPending(iP), .timerAIrq(tI), .extIrq0N(e0N),
    .wakeFromHaltN(wN), .serialExtClock(sX), .mode(mode), .mainOscEn(mO),
    .subOscEn(sO), .cpuClockEn(cC), .cpuUseSubClock(cS), .periphEn(pE),
    .serialEn(sE), .serialIrqEn(sIE), .comparatorEn(cE), .timerAEn(tE),
    .ioHold(iH), .ioHighZ(iZ), .cpuRestart(cR), .restartAddr(rA),
    .nopInstr(nop), .ramValidFlag(rV));
  // free running 40 MHz clock
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end
  // expected gating {main,sub,cpu,cpuSub,periph,comp,timerA,ioHold}
  function automatic logic [7:0] expGate(input logic [2:0] m, input logic s);
    case (m)
      3'h0: expGate = 8'hEE;
      3'h1: expGate = 8'hCB;
      3'h2: expGate = {1'h0, ~s, 6'h00};
      3'h3: expGate = 8'h43;
      default: expGate = 8'h7E;
    endcase
  endfunction
  // compare a value, case equality so unknowns fail
  task automatic chkVal(input logic [11:0] a, input logic [11:0] e);
    samplesChecked++;
    if (a !== e) begin
      nErrors++;
      $display("[FAIL] %0t value %h expected %h", $time, a, e);
    end
  endtask
  // compare the mode and the eight gating outputs of expGate it implies
  task automatic chkMode(input logic [2:0] m, input logic s);
    chkVal(12'(mode), 12'(m));
    chkVal(12'({mO, sO, cC, cS, pE, cE, tE, iH}), 12'(expGate(m, s)));
  endtask
  // wait out settling, bounded, and check its length
  task automatic waitSettle();
    n = 0;
    while (mode === 3'h5 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    chkVal(12'(n >= Settle - 1 && n <= Settle + 3), 12'h001);
  endtask
  // hop through watch into subactive on a timer a request
  task automatic toSub();
    @(posedge clock);
    cpu_u.timerAModeBit3 <= 1'h1;
    cpu_u.lowSpeedSelect <= 1'h1;
    cpu_u.instr(0);
    cpu_u.timerAIrq <= 1'h1;
    @(posedge clock);
    cpu_u.timerAIrq <= 1'h0;
    @(negedge clock);
    chkMode(3'h4, 1'h0);
  endtask
  // counts, then verdict, then end of run
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", nErrors, samplesChecked);
    if (nErrors == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // cycle ceiling against a hang
  always @(posedge clock) begin
    cyc++;
    if (cyc >= 5000) begin
      nErrors++;
      tally_and_finish();
    end
  end
  // main sequence
  initial begin
    {nErrors, samplesChecked, cyc} = 0;
    seed = 32'h72378711;
    nrst = 1'h0;
    repeat (10) @(posedge clock);
    chkVal(12'({mode, rV, mO, cR}), 12'({3'h0, 3'h2}));
    nrst <= 1'h1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    chkMode(3'h0, 1'h0);
    cpu_u.instr(1);
    @(negedge clock);
    chkMode(3'h1, 1'h0);
    @(posedge clock);
    cpu_u.wakeFromHaltN <= 1'h0;
    repeat (2) @(posedge clock);
    cpu_u.wakeFromHaltN <= 1'h1;
    @(negedge clock);
    chkMode(3'h1, 1'h0);
    @(posedge clock);
    cpu_u.irqPending <= 1'h1;
    @(posedge clock);
    cpu_u.irqPending <= 1'h0;
    @(negedge clock);
    chkMode(3'h0, 1'h0);
    chkVal(12'(cR), 12'h000);
    @(posedge clock);
    cpu_u.irqGlobalEnable <= 1'h0;
    cpu_u.irqPending <= 1'h1;
    cpu_u.instr(0);
    @(negedge clock);
    chkVal(12'(nop), 12'h001);
    chkMode(3'h0, 1'h0);
    @(posedge clock);
    cpu_u.irqPending <= 1'h0;
    cpu_u.irqGlobalEnable <= 1'($random(seed));
    cpu_u.timerAModeBit3 <= 1'h0;
    // stop entries with both sub osc choices, one random
    for (i = 0; i < 3; i++) begin
      sel = (i < 2) ? 1'(i) : 1'($random(seed));
      @(posedge clock);
      cpu_u.subOscHaltSel <= sel;
      // speed flags do not matter in active or stop, so vary them
      cpu_u.lowSpeedSelect <= 1'($random(seed));
      cpu_u.directTransitionFlag <= 1'($random(seed));
      cpu_u.instr(0);
      @(negedge clock);
      chkMode(3'h2, sel);
      chkVal(12'(iZ), 12'h001);
      @(posedge clock);
      cpu_u.wakeFromHaltN <= 1'h0;
      @(posedge clock);
      @(negedge clock);
      chkVal(12'({mode, rV, cC}), 12'({3'h5, 2'h2}));
      waitSettle();
      chkVal(12'(cR), 12'h001);
      chkVal(rA, 12'h000);
      chkMode(3'h0, 1'h0);
      // pin released only after the full settle wait
      @(posedge clock);
      cpu_u.wakeFromHaltN <= 1'h1;
    end
    // reset out of standby and out of stop
    for (i = 0; i < 2; i++) begin
      cpu_u.instr(i == 0);
      @(posedge clock);
      nrst <= 1'h0;
      @(posedge clock);
      nrst <= 1'h1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chkVal(12'({mode, rV}), 12'h000);
    end
    @(posedge clock);
    cpu_u.serialExtClock <= 1'($random(seed));
    cpu_u.timerAModeBit3 <= 1'h1;
    cpu_u.instr(0);
    @(negedge clock);
    chkMode(3'h3, 1'h0);
    chkVal(12'({sE, sIE}), 12'({sX, 1'h0}));
    // timer a wake with the low speed flag set lands in subactive
    @(posedge clock);
    cpu_u.lowSpeedSelect <= 1'h1;
    cpu_u.timerAIrq <= 1'h1;
    @(posedge clock);
    cpu_u.timerAIrq <= 1'h0;
    @(negedge clock);
    chkMode(3'h4, 1'h0);
    // back to watch from subactive with both flags low
    @(posedge clock);
    cpu_u.lowSpeedSelect <= 1'h0;
    cpu_u.directTransitionFlag <= 1'h0;
    cpu_u.instr(0);
    @(negedge clock);
    chkMode(3'h3, 1'h0);
    @(posedge clock);
    cpu_u.extIrq0N <= 1'h0;
    @(posedge clock);
    cpu_u.extIrq0N <= 1'h1;
    @(negedge clock);
    chkVal(12'(mode), 12'h005);
    waitSettle();
    chkMode(3'h0, 1'h0);
    chkVal(12'(cR), 12'h000);
    toSub();
    @(posedge clock);
    cpu_u.lowSpeedSelect <= 1'h0;
    cpu_u.directTransitionFlag <= 1'h1;
    cpu_u.instr(1);
    @(negedge clock);
    chkVal(12'(mode), 12'h005);
    waitSettle();
    chkMode(3'h0, 1'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
